// ===== design/alarm_status_manager.sv
// alarm aggregation, memorising, counting, time logging and relay drive
module alarm_status_manager #(
  parameter int TICK_CYCLES = asm_pkg::TICK_CYCLES,
  parameter int PPS_CYCLES = asm_pkg::PPS_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic controller_reset_event,
  input wire logic selftest_done,
  input wire logic selftest_pass,
  output logic selftest_start,
  input wire logic ref_clock_fault,
  input wire logic temp_fault,
  input wire logic [3:0] supply_fault,
  input wire logic [3:0] iface_missing,
  input wire logic [3:0] iface_invalid,
  input wire logic framing_absent,
  input wire logic asi_code_violation,
  input wire logic hssi_signal_loss,
  input wire logic asi_optical_loss,
  input wire logic [1:0] g703_rx_loss,
  input wire logic lvds_signal_loss,
  input wire logic [1:0] g703_code_violation,
  input wire logic gps_pps,
  input wire logic setting_conflict,
  output logic [15:0] pending_setting,
  output logic [15:0] applied_setting,
  output logic [17:0] alarm_active,
  output logic general_device_alarm,
  output logic input_interface_alarm,
  output logic supply_summary_alarm,
  output logic relay_closed
);

  localparam int N = asm_pkg::NUM_ALARMS;
  localparam int TW = asm_pkg::TS_W;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic expert;
    logic int_framing;
    logic opt_asi;
    logic opt_hssi_g703;
    logic [1:0] iface_sel;
    asm_pkg::asm_mode_t [N-1:0] mode;
    logic [N-1:0] act;
    logic [N-1:0] seen;
    logic [N-1:0][7:0] cnt;
    logic [N-1:0][TW-1:0] start_ts;
    logic [N-1:0][TW-1:0] stop_ts;
    logic [TW-1:0] now_ts;
    logic [asm_pkg::TICK_CNT_W-1:0] tick_cnt;
    logic [asm_pkg::PPS_CNT_W-1:0] pps_cnt;
    logic pps_miss;
    logic reset_seen;
    logic st_start;
    logic st_fail;
    logic [asm_pkg::SET_W-1:0] pending;
    logic [asm_pkg::SET_W-1:0] applied;
    logic relay;
    logic supply;
    logic [31:0] rdata;
  } asm_state_t;

  asm_state_t st_reg;
  asm_state_t st_next;

  // condition and effective alarm vectors, built each cycle
  logic [N-1:0] cond;
  logic [N-1:0] eff;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  logic [N-1:0] memo;
  logic [N-1:0] listed;
  logic general_cond;
  logic clear_cmd;
  logic alm_hit;
  logic time_hit;
  logic [11:0] alm_ofs;
  logic [11:0] time_ofs;
  localparam int IDX_W_L = asm_pkg::IDX_W;
  logic [IDX_W_L-1:0] alm_idx;
  logic [IDX_W_L-1:0] time_idx;
  localparam logic [asm_pkg::TICK_CNT_W-1:0] TICK_LAST =
    asm_pkg::TICK_CNT_W'(TICK_CYCLES - 1);
  localparam logic [asm_pkg::PPS_CNT_W-1:0] PPS_LAST =
    asm_pkg::PPS_CNT_W'(PPS_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // condition sources

  // raw conditions gated by interface selection, options and framing mode
  always_comb
  begin
    cond = '0;
    cond[asm_pkg::ALM_CTRL_RESET] = st_reg.reset_seen;
    cond[asm_pkg::ALM_SELFTEST] = st_reg.st_fail;
    cond[asm_pkg::ALM_INCOMPAT] = (st_reg.pending != st_reg.applied);
    cond[asm_pkg::ALM_INTERFACE] = iface_missing[st_reg.iface_sel]
      | iface_invalid[st_reg.iface_sel];
    cond[asm_pkg::ALM_REF_CLOCK] = ref_clock_fault;
    cond[asm_pkg::ALM_TEMP] = temp_fault;
    cond[asm_pkg::ALM_SUPPLY] = |supply_fault;
    cond[asm_pkg::ALM_FRAMING] = framing_absent & ~st_reg.int_framing;
    cond[asm_pkg::ALM_SERIAL_CV] = asi_code_violation & st_reg.opt_asi;
    cond[asm_pkg::ALM_HSSI_LOSS] = hssi_signal_loss & st_reg.opt_hssi_g703;
    cond[asm_pkg::ALM_OPTICAL_LOSS] = asi_optical_loss & st_reg.opt_asi;
    cond[asm_pkg::ALM_G703_RX1] = g703_rx_loss[0] & st_reg.opt_hssi_g703;
    cond[asm_pkg::ALM_LVDS_LOSS] = lvds_signal_loss & st_reg.opt_asi;
    cond[asm_pkg::ALM_G703_RX2] = g703_rx_loss[1] & st_reg.opt_hssi_g703;
    cond[asm_pkg::ALM_G703_CV1] = g703_code_violation[0] & st_reg.opt_hssi_g703;
    cond[asm_pkg::ALM_TIME_REF] = st_reg.pps_miss & st_reg.opt_asi;
    cond[asm_pkg::ALM_G703_CV2] = g703_code_violation[1] & st_reg.opt_hssi_g703;
  end

  // general alarm: OR of unmasked real conditions, forced ones left out
  always_comb
  begin
    general_cond = 1'b0;
    for (int i = 0; i < N; i++)
    begin
      if (i != asm_pkg::ALM_GENERAL && st_reg.mode[i] == asm_pkg::ASM_MODE_NORMAL)
      begin
        general_cond = general_cond | cond[i];
      end
    end
  end

  // effective alarm per mode: forced raises, masked drops, normal follows
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      if (st_reg.mode[i] == asm_pkg::ASM_MODE_FORCED)
      begin
        eff[i] = 1'b1;
      end
      else if (st_reg.mode[i] == asm_pkg::ASM_MODE_MASKED)
      begin
        eff[i] = 1'b0;
      end
      else if (i == asm_pkg::ALM_GENERAL)
      begin
        eff[i] = general_cond;
      end
      else
      begin
        eff[i] = cond[i];
      end
    end
  end

  // edges, memorised and listed views
  assign rise = eff & ~st_reg.act;
  assign fall = ~eff & st_reg.act;
  assign memo = st_reg.seen & ~st_reg.act;
  assign listed = st_reg.expert ? {N{1'b1}} : (st_reg.act | memo);

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  // clear command and per-alarm windows
  assign clear_cmd = reg_wr && reg_addr == asm_pkg::OFS_CTRL
    && reg_wdata[asm_pkg::CTRL_CLEAR];
  assign alm_ofs = reg_addr - asm_pkg::OFS_ALARM_BASE;
  assign time_ofs = reg_addr - asm_pkg::OFS_TIME_BASE;
  assign alm_idx = alm_ofs[IDX_W_L+1:2];
  assign time_idx = time_ofs[IDX_W_L+1:2];
  assign alm_hit = reg_addr >= asm_pkg::OFS_ALARM_BASE
    && reg_addr < asm_pkg::OFS_ALARM_END && reg_addr[1:0] == 2'h0;
  assign time_hit = reg_addr >= asm_pkg::OFS_TIME_BASE
    && reg_addr < asm_pkg::OFS_TIME_END && reg_addr[1:0] == 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    asm_pkg::asm_mode_t wmode;
    wmode = asm_pkg::asm_mode_t'(reg_wdata[1:0]);
    st_next = st_reg;
    st_next.st_start = 1'b0;

    // control register write; leaving expert reverts forced alarms
    if (reg_wr && reg_addr == asm_pkg::OFS_CTRL)
    begin
      st_next.expert = reg_wdata[asm_pkg::CTRL_EXPERT];
      st_next.int_framing = reg_wdata[asm_pkg::CTRL_INT_FRAMING];
      st_next.opt_asi = reg_wdata[asm_pkg::CTRL_OPT_ASI];
      st_next.opt_hssi_g703 = reg_wdata[asm_pkg::CTRL_OPT_HSSI_G703];
      st_next.iface_sel = reg_wdata[asm_pkg::CTRL_SEL_HI:asm_pkg::CTRL_SEL_LO];
      if (st_reg.expert && !reg_wdata[asm_pkg::CTRL_EXPERT])
      begin
        for (int i = 0; i < N; i++)
        begin
          if (st_reg.mode[i] == asm_pkg::ASM_MODE_FORCED)
          begin
            st_next.mode[i] = asm_pkg::ASM_MODE_NORMAL;
          end
        end
      end
    end
    else if (reg_wr && alm_hit)
    begin
      // mode change; mask and force only accepted in expert mode
      if (wmode == asm_pkg::ASM_MODE_NORMAL)
      begin
        st_next.mode[alm_idx] = wmode;
      end
      else if ((wmode == asm_pkg::ASM_MODE_MASKED || wmode == asm_pkg::ASM_MODE_FORCED)
        && st_reg.expert)
      begin
        st_next.mode[alm_idx] = wmode;
      end
    end
    else if (reg_wr && reg_addr == asm_pkg::OFS_SETTING_REQ)
    begin
      st_next.pending = reg_wdata[asm_pkg::SET_W-1:0];
    end

    // pending setting goes live only once it no longer conflicts
    if (!setting_conflict)
    begin
      st_next.applied = st_reg.pending;
    end

    // per-alarm tracking; an edge in the clear cycle wins over the clear
    st_next.act = eff;
    for (int i = 0; i < N; i++)
    begin
      if (clear_cmd)
      begin
        st_next.seen[i] = 1'b0;
        st_next.cnt[i] = 8'h00;
        if (!eff[i])
        begin
          st_next.start_ts[i] = '0;
          st_next.stop_ts[i] = '0;
        end
      end
      if (rise[i])
      begin
        st_next.seen[i] = 1'b1;
        st_next.start_ts[i] = st_reg.now_ts;
        if (clear_cmd)
        begin
          st_next.cnt[i] = 8'h01;
        end
        else if (st_reg.cnt[i] != asm_pkg::CNT_MAX)
        begin
          st_next.cnt[i] = st_reg.cnt[i] + 8'h01;
        end
      end
      if (fall[i])
      begin
        st_next.stop_ts[i] = st_reg.now_ts;
      end
    end

    // controller reset flag, cleared by the operator clear
    if (controller_reset_event)
    begin
      st_next.reset_seen = 1'b1;
    end
    else if (clear_cmd)
    begin
      st_next.reset_seen = 1'b0;
    end

    // self test outcome
    if (selftest_done && !selftest_pass)
    begin
      st_next.st_fail = 1'b1;
    end

    // time stamp tick
    if (st_reg.tick_cnt == TICK_LAST)
    begin
      st_next.tick_cnt = '0;
      st_next.now_ts = st_reg.now_ts + 16'h0001;
    end
    else
    begin
      st_next.tick_cnt = st_reg.tick_cnt + 1'b1;
    end

    // pulse-per-second watchdog
    if (gps_pps)
    begin
      st_next.pps_cnt = '0;
      st_next.pps_miss = 1'b0;
    end
    else if (st_reg.pps_cnt == PPS_LAST)
    begin
      st_next.pps_miss = 1'b1;
    end
    else
    begin
      st_next.pps_cnt = st_reg.pps_cnt + 1'b1;
    end

    // relay and summary outputs
    st_next.relay = eff[asm_pkg::ALM_GENERAL] | eff[asm_pkg::ALM_INTERFACE];
    st_next.supply = eff[asm_pkg::ALM_SUPPLY];

    // read data, valid in the cycle after the strobe
    st_next.rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      if (reg_addr == asm_pkg::OFS_CTRL)
      begin
        st_next.rdata[asm_pkg::CTRL_EXPERT] = st_reg.expert;
        st_next.rdata[asm_pkg::CTRL_INT_FRAMING] = st_reg.int_framing;
        st_next.rdata[asm_pkg::CTRL_OPT_ASI] = st_reg.opt_asi;
        st_next.rdata[asm_pkg::CTRL_OPT_HSSI_G703] = st_reg.opt_hssi_g703;
        st_next.rdata[asm_pkg::CTRL_SEL_HI:asm_pkg::CTRL_SEL_LO] = st_reg.iface_sel;
      end
      else if (reg_addr == asm_pkg::OFS_ACTUAL)
      begin
        st_next.rdata[N-1:0] = st_reg.act;
      end
      else if (reg_addr == asm_pkg::OFS_MEMO)
      begin
        st_next.rdata[N-1:0] = memo;
      end
      else if (reg_addr == asm_pkg::OFS_LISTED)
      begin
        st_next.rdata[N-1:0] = listed;
      end
      else if (reg_addr == asm_pkg::OFS_SETTING_REQ)
      begin
        st_next.rdata[asm_pkg::SET_W-1:0] = st_reg.pending;
      end
      else if (reg_addr == asm_pkg::OFS_SETTING_APPLIED)
      begin
        st_next.rdata[asm_pkg::SET_W-1:0] = st_reg.applied;
      end
      else if (alm_hit)
      begin
        st_next.rdata[7:0] = st_reg.cnt[alm_idx];
        st_next.rdata[asm_pkg::AST_MODE_LO+1:asm_pkg::AST_MODE_LO] = st_reg.mode[alm_idx];
        st_next.rdata[asm_pkg::AST_MEMO] = memo[alm_idx];
        st_next.rdata[asm_pkg::AST_ACTUAL] = st_reg.act[alm_idx];
        st_next.rdata[asm_pkg::AST_LISTED] = listed[alm_idx];
        st_next.rdata[asm_pkg::AST_OK] = st_reg.expert
          && !st_reg.act[alm_idx] && !memo[alm_idx];
      end
      else if (time_hit)
      begin
        if (st_reg.act[time_idx])
        begin
          st_next.rdata = {asm_pkg::TS_STILL_ACTIVE, st_reg.start_ts[time_idx]};
        end
        else if (memo[time_idx])
        begin
          st_next.rdata = {st_reg.stop_ts[time_idx], st_reg.start_ts[time_idx]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_reg <= '0;
      st_reg.reset_seen <= 1'b1;
      st_reg.st_start <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // all outputs straight from the state register
  assign reg_rdata = st_reg.rdata;
  assign selftest_start = st_reg.st_start;
  assign pending_setting = st_reg.pending;
  assign applied_setting = st_reg.applied;
  assign alarm_active = st_reg.act;
  assign general_device_alarm = st_reg.act[asm_pkg::ALM_GENERAL];
  assign input_interface_alarm = st_reg.act[asm_pkg::ALM_INTERFACE];
  assign supply_summary_alarm = st_reg.supply;
  assign relay_closed = st_reg.relay;

endmodule : alarm_status_manager

// ===== inc/asm_pkg.sv
// constants, field layouts and types shared by the alarm status manager
package asm_pkg;

  // alarm table size and slots
  localparam int NUM_ALARMS = 18;
  localparam int IDX_W = 5;
  localparam int ALM_CTRL_RESET = 0;
  localparam int ALM_SELFTEST = 1;
  localparam int ALM_INCOMPAT = 2;
  localparam int ALM_GENERAL = 3;
  localparam int ALM_INTERFACE = 4;
  localparam int ALM_REF_CLOCK = 5;
  localparam int ALM_TEMP = 6;
  localparam int ALM_SUPPLY = 7;
  localparam int ALM_FRAMING = 8;
  localparam int ALM_SERIAL_CV = 9;
  localparam int ALM_HSSI_LOSS = 10;
  localparam int ALM_OPTICAL_LOSS = 11;
  localparam int ALM_G703_RX1 = 12;
  localparam int ALM_LVDS_LOSS = 13;
  localparam int ALM_G703_RX2 = 14;
  localparam int ALM_G703_CV1 = 15;
  localparam int ALM_TIME_REF = 16;
  localparam int ALM_G703_CV2 = 17;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_ACTUAL = 12'h004;
  localparam logic [11:0] OFS_MEMO = 12'h008;
  localparam logic [11:0] OFS_LISTED = 12'h00c;
  localparam logic [11:0] OFS_SETTING_REQ = 12'h010;
  localparam logic [11:0] OFS_SETTING_APPLIED = 12'h014;
  localparam logic [11:0] OFS_ALARM_BASE = 12'h040;
  localparam logic [11:0] OFS_ALARM_END = 12'h088;
  localparam logic [11:0] OFS_TIME_BASE = 12'h100;
  localparam logic [11:0] OFS_TIME_END = 12'h148;

  // control register bit positions
  localparam int CTRL_EXPERT = 0;
  localparam int CTRL_CLEAR = 1;
  localparam int CTRL_INT_FRAMING = 2;
  localparam int CTRL_OPT_ASI = 3;
  localparam int CTRL_OPT_HSSI_G703 = 4;
  localparam int CTRL_SEL_LO = 5;
  localparam int CTRL_SEL_HI = 6;

  // per-alarm status word bit positions
  localparam int AST_MODE_LO = 8;
  localparam int AST_MEMO = 10;
  localparam int AST_ACTUAL = 11;
  localparam int AST_LISTED = 12;
  localparam int AST_OK = 13;

  // counter and time stamp figures
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam int TS_W = 16;
  localparam logic [15:0] TS_STILL_ACTIVE = 16'hffff;
  localparam int SET_W = 16;

  // timing: clock rate, time stamp tick and pulse-per-second window
  localparam int CLK_KHZ = 100000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
  localparam int PPS_WINDOW_MS = 1500;
  localparam int PPS_CYCLES = PPS_WINDOW_MS * CLK_KHZ;
  localparam int TICK_CNT_W = 17;
  localparam int PPS_CNT_W = 28;

  // per-alarm mode
  typedef enum logic [1:0] {
    ASM_MODE_NORMAL = 2'h0,
    ASM_MODE_MASKED = 2'h1,
    ASM_MODE_FORCED = 2'h2
  } asm_mode_t;

endpackage : asm_pkg

// ===== test/alarm_status_manager_chk.sv
// port-level checks for the alarm status manager
module asm_status_chk #(
  parameter int TICK_CYCLES = 4,
  parameter int PPS_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic selftest_done,
  input wire logic selftest_pass,
  input wire logic selftest_start,
  input wire logic [3:0] supply_fault,
  input wire logic [3:0] iface_missing,
  input wire logic [3:0] iface_invalid,
  input wire logic setting_conflict,
  input wire logic [15:0] pending_setting,
  input wire logic [15:0] applied_setting,
  input wire logic [17:0] alarm_active,
  input wire logic general_device_alarm,
  input wire logic input_interface_alarm,
  input wire logic relay_closed
);
  timeunit 1ns;
  timeprecision 1ps;
  logic modes_clean_reg;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // drops once any alarm mode other than normal was requested
  always_ff @(posedge core_clk)
  begin
    if (rst)
      modes_clean_reg <= 1'b1;
    else if (reg_wr && reg_addr >= asm_pkg::OFS_ALARM_BASE && reg_wdata[1:0] != 2'h0
             && reg_addr < asm_pkg::OFS_ALARM_END)
      modes_clean_reg <= 1'b0;
  end

  ////////////////////////////////////////
  a_relay_follows: assert property (relay_closed ==
    (general_device_alarm | input_interface_alarm))
    else $error("relay differs from general or interface alarm");
  a_general_mirror: assert property (general_device_alarm == alarm_active[3])
    else $error("general alarm port differs from its slot");
  a_supply_or: assert property (modes_clean_reg && !reg_wr
    |=> alarm_active[7] == $past(|supply_fault))
    else $error("supply summary not OR of inputs");
  a_general_or: assert property (modes_clean_reg && !reg_wr && (|supply_fault)
    |=> general_device_alarm)
    else $error("general alarm missing with a supply fault");
  a_iface_quiet: assert property (modes_clean_reg && !reg_wr && iface_missing == 4'h0
    && iface_invalid == 4'h0 |=> !input_interface_alarm)
    else $error("interface alarm without an interface fault");
  a_selftest_pulse: assert property ($fell(rst) |-> ##[0:1] selftest_start ##1 !selftest_start)
    else $error("self test start is not one pulse after reset");
  a_reset_flag: assert property ($fell(rst) |-> ##[0:2] alarm_active[0])
    else $error("reset flag alarm not raised after reset");
  a_selftest_fail: assert property (modes_clean_reg && selftest_done && !selftest_pass
    |=> ##1 alarm_active[1])
    else $error("failed self test did not raise its alarm");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  a_pending_store: assert property (reg_wr && reg_addr == asm_pkg::OFS_SETTING_REQ
    |=> pending_setting == $past(reg_wdata[15:0]))
    else $error("requested setting not stored");
  a_applied_copy: assert property (!setting_conflict
    |=> applied_setting == $past(pending_setting))
    else $error("setting not applied without a conflict");
  a_incompat_flag: assert property (modes_clean_reg && pending_setting != applied_setting
    |=> alarm_active[2])
    else $error("incompatibility alarm missing");
endmodule : asm_status_chk

bind alarm_status_manager asm_status_chk #(.TICK_CYCLES(TICK_CYCLES), .PPS_CYCLES(PPS_CYCLES))
  u_chk (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .selftest_done(selftest_done),
  .selftest_pass(selftest_pass), .selftest_start(selftest_start), .supply_fault(supply_fault),
  .iface_missing(iface_missing), .iface_invalid(iface_invalid),
  .setting_conflict(setting_conflict), .pending_setting(pending_setting),
  .applied_setting(applied_setting), .alarm_active(alarm_active),
  .general_device_alarm(general_device_alarm), .input_interface_alarm(input_interface_alarm),
  .relay_closed(relay_closed));

// ===== test/alarm_status_manager_tb_top.sv
// self-checking bench for the alarm status manager
module alarm_status_manager_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0] sup;
    logic [3:0] mis;
    logic [3:0] inv;
    logic [2:0] cond;
    logic [2:0] exp;
  } asm_row_t;
  localparam asm_row_t ROWS [9] = '{'{4'h0, 4'h0, 4'h0, 3'h0, 3'h0},
    '{4'h8, 4'h0, 4'h0, 3'h0, 3'h5}, '{4'h1, 4'h0, 4'h0, 3'h0, 3'h5},
    '{4'h0, 4'h1, 4'h0, 3'h0, 3'h6}, '{4'h0, 4'h2, 4'h0, 3'h0, 3'h0},
    '{4'h0, 4'h0, 4'h1, 3'h0, 3'h6}, '{4'h0, 4'h0, 4'h0, 3'h4, 3'h4},
    '{4'h0, 4'h0, 4'h0, 3'h2, 3'h4}, '{4'h0, 4'h0, 4'h0, 3'h1, 3'h4}};
  localparam logic [11:0] TEMP_ALM = asm_pkg::OFS_ALARM_BASE + 12'h018;
  localparam logic [11:0] TEMP_TIME = asm_pkg::OFS_TIME_BASE + 12'h018;
  logic core_clk, rst, reg_wr, reg_rd, selftest_start, gps_pps, setting_conflict;
  logic selftest_done, selftest_pass, ref_clock_fault, temp_fault, framing_absent;
  logic asi_code_violation, hssi_signal_loss, asi_optical_loss, lvds_signal_loss;
  logic general_device_alarm, input_interface_alarm, supply_summary_alarm, relay_closed;
  logic [1:0] g703_rx_loss, g703_code_violation;
  logic [3:0] supply_fault, iface_missing, iface_invalid;
  logic [11:0] reg_addr;
  logic [15:0] pending_setting, applied_setting;
  logic [17:0] alarm_active;
  logic [31:0] reg_wdata, reg_rdata, d;
  int miscompares = 0;
  int comparisons = 0;

  // 100 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  alarm_status_manager #(.TICK_CYCLES(4), .PPS_CYCLES(20)) dut (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .controller_reset_event(1'b0), .selftest_done(selftest_done),
    .selftest_pass(selftest_pass), .selftest_start(selftest_start),
    .ref_clock_fault(ref_clock_fault), .temp_fault(temp_fault), .supply_fault(supply_fault),
    .iface_missing(iface_missing), .iface_invalid(iface_invalid),
    .framing_absent(framing_absent), .asi_code_violation(asi_code_violation),
    .hssi_signal_loss(hssi_signal_loss), .asi_optical_loss(asi_optical_loss),
    .g703_rx_loss(g703_rx_loss), .lvds_signal_loss(lvds_signal_loss),
    .g703_code_violation(g703_code_violation), .gps_pps(gps_pps),
    .setting_conflict(setting_conflict), .pending_setting(pending_setting),
    .applied_setting(applied_setting), .alarm_active(alarm_active),
    .general_device_alarm(general_device_alarm), .input_interface_alarm(input_interface_alarm),
    .supply_summary_alarm(supply_summary_alarm), .relay_closed(relay_closed));

  asm_operator op (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  ////////////////////////////////////////
  // verdict and end of run
  task automatic end_of_test();
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle

  // bounded wait on one alarm slot; running out ends the run
  task automatic wait_alarm(input int slot, input int bound);
    int i;
    i = 0;
    while (alarm_active[slot] !== 1'b1 && i < bound)
    begin
      settle(1);
      i++;
    end
    if (alarm_active[slot] !== 1'b1)
    begin
      miscompares++;
      end_of_test();
    end
  endtask : wait_alarm

  // reset held 8 cycles, then start pulse and reset flag
  task automatic do_reset();
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk(32'(selftest_start), 32'h1);
    settle(1);
    chk(32'(selftest_start), 32'h0);
    wait_alarm(0, 4);
  endtask : do_reset

  // temp pulses: high one cycle, low one cycle
  task automatic pulse_temp(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      temp_fault <= 1'b1;
      @(posedge core_clk);
      temp_fault <= 1'b0;
    end
    settle(2);
  endtask : pulse_temp

  ////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    {selftest_done, selftest_pass, ref_clock_fault, temp_fault, framing_absent} = 5'h0;
    {asi_code_violation, hssi_signal_loss, asi_optical_loss, lvds_signal_loss} = 4'h0;
    {g703_rx_loss, g703_code_violation, gps_pps, setting_conflict} = 6'h0;
    {supply_fault, iface_missing, iface_invalid} = 12'h0;
    do_reset();
    op.write_word(asm_pkg::OFS_CTRL, 32'h2);
    settle(1);
    chk(32'(alarm_active), 32'h0);
    // table of condition inputs against summary outputs
    foreach (ROWS[i])
    begin
      @(posedge core_clk);
      {supply_fault, iface_missing, iface_invalid} <= {ROWS[i].sup, ROWS[i].mis, ROWS[i].inv};
      {temp_fault, ref_clock_fault, framing_absent} <= ROWS[i].cond;
      settle(1);
      chk(32'(general_device_alarm), 32'(ROWS[i].exp[2]));
      chk(32'(input_interface_alarm), 32'(ROWS[i].exp[1]));
      chk(32'(supply_summary_alarm), 32'(ROWS[i].exp[0]));
      chk(32'(relay_closed), 32'(ROWS[i].exp[2] | ROWS[i].exp[1]));
    end
    framing_absent <= 1'b0;
    op.write_word(asm_pkg::OFS_CTRL, 32'h2);
    // occurrences, memorised state, times and saturation
    temp_fault <= 1'b1;
    settle(2);
    op.read_word(TEMP_ALM, d);
    chk(32'(d[11]), 32'h1);
    op.read_word(TEMP_TIME, d);
    chk(32'(d[31:16]), 32'hffff);
    pulse_temp(2);
    op.read_word(TEMP_ALM, d);
    chk(32'(d[11:10]), 32'h1);
    chk(32'(d[7:0]), 32'h2);
    op.read_word(asm_pkg::OFS_MEMO, d);
    chk(32'(d[6]), 32'h1);
    op.read_word(TEMP_TIME, d);
    chk(32'(d[31:16] == 16'hffff), 32'h0);
    pulse_temp(254);
    op.read_word(TEMP_ALM, d);
    chk(32'(d[7:0]), 32'hff);
    op.write_word(asm_pkg::OFS_CTRL, 32'h2);
    op.read_word(TEMP_ALM, d);
    chk(32'(d[10]), 32'h0);
    chk(32'(d[7:0]), 32'h0);
    op.read_word(TEMP_TIME, d);
    chk(d, 32'h0);
    op.read_word(asm_pkg::OFS_LISTED, d);
    chk(32'(d[17:0]), 32'h0);
    op.read_word(12'h800, d);
    chk(d, 32'h0);
    // conflicting setting held, then applied
    setting_conflict <= 1'b1;
    op.write_word(asm_pkg::OFS_SETTING_REQ, 32'h1234);
    settle(2);
    chk(32'(applied_setting), 32'h0);
    chk(32'(alarm_active[2]), 32'h1);
    setting_conflict <= 1'b0;
    settle(3);
    chk(32'(applied_setting), 32'h1234);
    chk(32'(alarm_active[2]), 32'h0);
    // modes: masking refused outside expert, then mask and force in expert
    op.write_word(TEMP_ALM, 32'h1);
    op.read_word(TEMP_ALM, d);
    chk(32'(d[9:8]), 32'h0);
    op.write_word(asm_pkg::OFS_CTRL, 32'h1);
    op.read_word(asm_pkg::OFS_LISTED, d);
    chk(32'(d[17:0]), 32'h3ffff);
    op.read_word(TEMP_ALM, d);
    chk(32'(d[13]), 32'h1);
    op.write_word(TEMP_ALM, 32'h1);
    op.write_word(asm_pkg::OFS_ALARM_BASE + 12'h014, 32'h2);
    op.read_word(TEMP_ALM, d);
    chk(32'(d[9:8]), 32'h1);
    temp_fault <= 1'b1;
    settle(2);
    chk(32'(alarm_active[6]), 32'h0);
    chk(32'(alarm_active[5]), 32'h1);
    chk(32'(general_device_alarm), 32'h0);
    chk(32'(relay_closed), 32'h0);
    op.write_word(asm_pkg::OFS_CTRL, 32'h0);
    op.read_word(asm_pkg::OFS_ALARM_BASE + 12'h014, d);
    chk(32'(d[9:8]), 32'h0);
    op.read_word(TEMP_ALM, d);
    chk(32'(d[9:8]), 32'h1);
    chk(32'(alarm_active[6]), 32'h0);
    temp_fault <= 1'b0;
    // option gating and missing pulse per second
    asi_code_violation <= 1'b1;
    settle(2);
    chk(32'(alarm_active[9]), 32'h0);
    op.write_word(asm_pkg::OFS_CTRL, 32'h8);
    settle(2);
    chk(32'(alarm_active[9]), 32'h1);
    asi_code_violation <= 1'b0;
    wait_alarm(16, 60);
    gps_pps <= 1'b1;
    @(posedge core_clk);
    gps_pps <= 1'b0;
    settle(3);
    chk(32'(alarm_active[16]), 32'h0);
    // failed self test between a second and a third reset in mid-run
    do_reset();
    selftest_done <= 1'b1;
    @(posedge core_clk);
    selftest_done <= 1'b0;
    settle(2);
    chk(32'(alarm_active[1]), 32'h1);
    do_reset();
    chk(32'(alarm_active[1]), 32'h0);
    end_of_test();
  end
endmodule : alarm_status_manager_tb_top

// ===== test/asm_operator.sv
// operator side model: issues register writes and reads like a front panel
module asm_operator (
  input wire logic core_clk,
  input wire logic [31:0] reg_rdata,
  output logic [11:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial
  begin
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // one-cycle write; released lines show inverted values so stale data is not trusted
  task automatic write_word(input logic [11:0] addr, input logic [31:0] data);
    @(posedge core_clk);
    reg_addr <= addr;
    reg_wdata <= data;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~addr;
    reg_wdata <= ~data;
  endtask : write_word

  // one-cycle read; data taken in the single cycle it stands
  task automatic read_word(input logic [11:0] addr, output logic [31:0] data);
    @(posedge core_clk);
    reg_addr <= addr;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~addr;
    #1;
    data = reg_rdata;
  endtask : read_word
endmodule : asm_operator
